// >>> rtl/hsd_pkg.sv
// package: register map, field positions and carriers for the high-side driver control
package hsd_pkg;
  localparam logic [7:0] HSD_OFS_CONTROL = 8'h28;
  localparam logic [7:0] HSD_OFS_STATUS = 8'h29;
  localparam logic [11:0] HSD_BASE_BLOCKING = 12'h200;
  localparam logic [11:0] HSD_BASE_NONBLOCKING = 12'h300;
  localparam logic [7:0] HSD_CONTROL_RESET = 8'h00;
  localparam int HSD_BIT_OT_IRQ_EN = 7;
  localparam int HSD_BIT_HV_SD_EN = 6;
  localparam int HSD_BIT_CS_TWO = 5;
  localparam int HSD_BIT_CS_ONE = 4;
  localparam int HSD_BIT_PWM_TWO = 3;
  localparam int HSD_BIT_PWM_ONE = 2;
  localparam int HSD_BIT_DRV_TWO = 1;
  localparam int HSD_BIT_DRV_ONE = 0;
  localparam int HSD_BIT_OT_PRESENT = 7;
  localparam int HSD_BIT_CL_TWO = 3;
  localparam int HSD_BIT_CL_ONE = 2;
  localparam int HSD_BIT_OL_TWO = 1;
  localparam int HSD_BIT_OL_ONE = 0;

  // analog sense inputs per driver
  typedef struct packed {
    logic open_load;
    logic current_limit;
  } hsd_sense_t;

  // register access request from the die-to-die port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } hsd_req_t;
endpackage

// >>> rtl/hsd_ctrl.sv
// high-side driver control: control/status registers, shutdown latching, pwm steering
// Summary of operation
// - open-load bit set when current below threshold
// - no open-load report while driver off
// - current-limit bit set while limiting
// - overtemperature shuts both drivers, latches interrupt event
// - thermal shutdown sets overtemperature status bit
// - re-enable by control write after overtemperature clears
// - high voltage with enable shuts both drivers
// - re-enable by control write after high voltage gone
// - drivers may stay enabled in sleep/stop
// - bit 7 gates overtemperature interrupt request
// - bit 6 enables high-voltage shutdown
// - bit 5 selects pwm channel driver two
// - bit 4 selects pwm channel driver one
// - bit 3 enables pwm on driver two
// - control at 0x28, reset zero, two bases
// - bit 2 enables pwm on driver one
// - bits 1,0 enable driver two, one
// - status bit 7 overtemp; read clears flag
// - status bits 3,2 limit; 1,0 open load
`timescale 1ns/1ns
`default_nettype none
module hsd_ctrl
  import hsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire hsd_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [1:0] pwm_channel,
  input wire hsd_sense_t sense_one,
  input wire hsd_sense_t sense_two,
  input wire logic overtemp_in,
  input wire logic high_voltage_condition,
  input wire logic low_power_mode,
  output logic driver_one_on,
  output logic driver_two_on,
  output logic overtemp_irq
);
  // analog inputs cross from outside the clock domain
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [1:0] pwm_a;
  logic [1:0] pwm_b;
  logic [7:0] driver_control;
  logic ot_latched;
  logic hv_latched;
  logic overtemp_shutdown_flag;
  logic ctrl_wr;
  logic stat_rd;
  logic sel_one;
  logic sel_two;
  logic pwm_ok_one;
  logic pwm_ok_two;
  logic next_one_on;
  logic next_two_on;
  logic [7:0] driver_status;
  logic ot_s;
  logic hv_s;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] ofs);
    hit = (a == (HSD_BASE_BLOCKING | {4'h0, ofs})) ||
          (a == (HSD_BASE_NONBLOCKING | {4'h0, ofs}));
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      pwm_a <= 2'h0;
      pwm_b <= 2'h0;
    end else if (ce) begin
      sync_a <= {high_voltage_condition, overtemp_in, sense_two, sense_one};
      sync_b <= sync_a;
      pwm_a <= pwm_channel;
      pwm_b <= pwm_a;
    end
  end

  assign ot_s = sync_b[4];
  assign hv_s = sync_b[5];
  assign ctrl_wr = ce && req.wr && hit(req.addr, HSD_OFS_CONTROL);
  assign stat_rd = ce && req.rd && hit(req.addr, HSD_OFS_STATUS);

  always_ff @(posedge clk) begin
    if (rst) begin
      driver_control <= HSD_CONTROL_RESET;
    end else if (ctrl_wr) begin
      driver_control <= req.wdata;
    end
  end

  // shutdown latches: a control write releases them only once the cause is gone
  always_ff @(posedge clk) begin
    if (rst) begin
      ot_latched <= 1'b0;
      hv_latched <= 1'b0;
    end else if (ce) begin
      if (ot_s) begin
        ot_latched <= 1'b1;
      end else if (ctrl_wr) begin
        ot_latched <= 1'b0;
      end
      if (hv_s && driver_control[HSD_BIT_HV_SD_EN]) begin
        hv_latched <= 1'b1;
      end else if (ctrl_wr) begin
        hv_latched <= 1'b0;
      end
    end
  end

  // interrupt flag: set wins over the clear-on-read
  always_ff @(posedge clk) begin
    if (rst) begin
      overtemp_shutdown_flag <= 1'b0;
    end else if (ce) begin
      if (ot_s && !ot_latched) begin
        overtemp_shutdown_flag <= 1'b1;
      end else if (stat_rd) begin
        overtemp_shutdown_flag <= 1'b0;
      end
    end
  end

  assign overtemp_irq = overtemp_shutdown_flag && driver_control[HSD_BIT_OT_IRQ_EN];

  assign sel_one = pwm_b[driver_control[HSD_BIT_CS_ONE]];
  assign sel_two = pwm_b[driver_control[HSD_BIT_CS_TWO]];
  assign pwm_ok_one = !driver_control[HSD_BIT_PWM_ONE] || sel_one;
  assign pwm_ok_two = !driver_control[HSD_BIT_PWM_TWO] || sel_two;
  // low_power_mode deliberately does not gate the drivers so cyclic sensing keeps working
  assign next_one_on = driver_control[HSD_BIT_DRV_ONE] && !ot_latched && !hv_latched
                       && !ot_s && pwm_ok_one;
  assign next_two_on = driver_control[HSD_BIT_DRV_TWO] && !ot_latched && !hv_latched
                       && !ot_s && pwm_ok_two;

  always_ff @(posedge clk) begin
    if (rst) begin
      driver_one_on <= 1'b0;
      driver_two_on <= 1'b0;
    end else if (ce) begin
      driver_one_on <= next_one_on;
      driver_two_on <= next_two_on;
    end
  end

  // sync_b packs {hv, ot, two.open_load, two.current_limit, one.open_load, one.current_limit}
  always_comb begin
    driver_status = 8'h00;
    driver_status[HSD_BIT_OT_PRESENT] = ot_s || ot_latched;
    driver_status[HSD_BIT_CL_TWO] = sync_b[2];
    driver_status[HSD_BIT_CL_ONE] = sync_b[0];
    driver_status[HSD_BIT_OL_TWO] = sync_b[3] && driver_two_on;
    driver_status[HSD_BIT_OL_ONE] = sync_b[1] && driver_one_on;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd;
      if (req.rd && hit(req.addr, HSD_OFS_CONTROL)) begin
        rdata <= driver_control;
      end else if (stat_rd) begin
        rdata <= driver_status;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  property p_ot_off;
    @(posedge clk) disable iff (rst) (ce && ot_s) |=> (!driver_one_on && !driver_two_on);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("driver on during overtemp");

  property p_hv_off;
    @(posedge clk) disable iff (rst)
      (ce && hv_s && driver_control[HSD_BIT_HV_SD_EN]) |=> ##1 (!driver_one_on && !driver_two_on);
  endproperty
  a_hv_off: assert property (p_hv_off) else $error("driver on during hv shutdown");

  property p_stay_off;
    @(posedge clk) disable iff (rst) (ot_latched && !ctrl_wr) |=> ot_latched;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("ot latch released without write");

  property p_hv_hold;
    @(posedge clk) disable iff (rst) (hv_latched && !ctrl_wr) |=> hv_latched;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("hv latch released without write");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
      (ce && ot_s && !ot_latched && driver_control[HSD_BIT_OT_IRQ_EN] && !ctrl_wr)
      |=> overtemp_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("overtemp event raised no irq");

  property p_ol_off;
    @(posedge clk) disable iff (rst) !driver_one_on |-> !driver_status[HSD_BIT_OL_ONE];
  endproperty
  a_ol_off: assert property (p_ol_off) else $error("open load reported while off");

  property p_en;
    @(posedge clk) disable iff (rst)
      driver_one_on |-> $past(driver_control[HSD_BIT_DRV_ONE]);
  endproperty
  a_en: assert property (p_en) else $error("driver one on without enable");

  property p_ot_status;
    @(posedge clk) disable iff (rst) ot_latched |-> driver_status[HSD_BIT_OT_PRESENT];
  endproperty
  a_ot_status: assert property (p_ot_status) else $error("overtemp status missing");

  property p_clr;
    @(posedge clk) disable iff (rst)
      (stat_rd && !ot_s) |=> !overtemp_shutdown_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared by read");

  property p_low_power;
    @(posedge clk) disable iff (rst)
      (ce && low_power_mode && next_one_on && next_two_on) |=> (driver_one_on && driver_two_on);
  endproperty
  a_low_power: assert property (p_low_power) else $error("driver dropped in low power");
endmodule
`default_nettype wire

// >>> verif/hsd_host.sv
// microcontroller-side model: single-byte register reads and writes
`timescale 1ns/1ns
`default_nettype none
module hsd_host
  import hsd_pkg::*;
(
  input wire logic clk,
  output hsd_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // address and data are scrambled after the strobe so stale values cannot pass
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
    @(posedge clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk) req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    d = rdata;
    v = rvalid;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the high-side driver control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hsd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  hsd_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] pwm_channel = 2'b00;
  hsd_sense_t sense_one = '0;
  hsd_sense_t sense_two = '0;
  logic overtemp_in = 1'b0;
  logic high_voltage_condition = 1'b0;
  logic low_power_mode = 1'b0;
  logic ce = 1'b1;
  logic driver_one_on;
  logic driver_two_on;
  logic overtemp_irq;
  int failures = 0;
  int compares = 0;
  always #50 clk = ~clk;
  hsd_ctrl DUT (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
    .pwm_channel(pwm_channel), .sense_one(sense_one), .sense_two(sense_two),
    .overtemp_in(overtemp_in), .high_voltage_condition(high_voltage_condition),
    .low_power_mode(low_power_mode), .driver_one_on(driver_one_on),
    .driver_two_on(driver_two_on), .overtemp_irq(overtemp_irq));
  hsd_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // inputs pass a 2-flop sync and a driver register: 3 edges, one spare
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_chk(string n, logic [11:0] a, logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    check("rvalid", 8'(v), 8'h01);
    check(n, d, exp);
  endtask
  task automatic drv_chk(logic e1, logic e2);
    check("drv1", 8'(driver_one_on), 8'(e1));
    check("drv2", 8'(driver_two_on), 8'(e2));
  endtask
  task automatic t_map;
    rd_chk("ctl", 12'h228, HSD_CONTROL_RESET);
    host.wr(12'h328, 8'h3C);
    host.wr(12'h229, 8'hFF);
    host.wr(12'h22A, 8'hFF);
    rd_chk("ctl", 12'h228, 8'h3C);
    rd_chk("sts", 12'h329, 8'h00);
    rd_chk("unmapped", 12'h22A, 8'h00);
  endtask
  task automatic t_pwm;
    logic [7:0] c;
    @(posedge clk) low_power_mode <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 64; i++) begin
        c = i[7:0];
        @(posedge clk) pwm_channel <= p[1:0];
        host.wr(12'h228, c);
        settle;
        drv_chk(c[0] & (~c[2] | p[c[4]]), c[1] & (~c[3] | p[c[5]]));
      end
    end
  endtask
  task automatic t_sense;
    host.wr(12'h228, 8'h03);
    @(posedge clk) begin
      sense_one <= '{open_load: 1'b1, current_limit: 1'b0};
      sense_two <= '{open_load: 1'b0, current_limit: 1'b1};
      pwm_channel <= 2'b00;
    end
    settle;
    rd_chk("sts", 12'h229, 8'h09);
    host.wr(12'h228, 8'h07);
    settle;
    rd_chk("sts", 12'h229, 8'h08);
    host.wr(12'h228, 8'h03);
    @(posedge clk) begin
      sense_one <= '{open_load: 1'b0, current_limit: 1'b1};
      sense_two <= '{open_load: 1'b1, current_limit: 1'b0};
    end
    settle;
    rd_chk("sts", 12'h229, 8'h06);
    @(posedge clk) sense_one <= '0;
    @(posedge clk) sense_two <= '0;
  endtask
  task automatic t_overtemp;
    host.wr(12'h228, 8'h83);
    @(posedge clk) overtemp_in <= 1'b1;
    settle;
    drv_chk(1'b0, 1'b0);
    check("irq", 8'(overtemp_irq), 8'h01);
    rd_chk("sts", 12'h229, 8'h80);
    check("irq", 8'(overtemp_irq), 8'h00);
    host.wr(12'h228, 8'h83);
    settle;
    drv_chk(1'b0, 1'b0);
    @(posedge clk) overtemp_in <= 1'b0;
    settle;
    drv_chk(1'b0, 1'b0);
    host.wr(12'h228, 8'h83);
    settle;
    drv_chk(1'b1, 1'b1);
    host.wr(12'h228, 8'h03);
    @(posedge clk) overtemp_in <= 1'b1;
    settle;
    check("irq", 8'(overtemp_irq), 8'h00);
    @(posedge clk) overtemp_in <= 1'b0;
    settle;
    rd_chk("sts", 12'h229, 8'h80);
  endtask
  task automatic t_hv;
    host.wr(12'h228, 8'h03);
    @(posedge clk) high_voltage_condition <= 1'b1;
    settle;
    drv_chk(1'b1, 1'b1);
    host.wr(12'h228, 8'h43);
    settle;
    drv_chk(1'b0, 1'b0);
    @(posedge clk) high_voltage_condition <= 1'b0;
    settle;
    drv_chk(1'b0, 1'b0);
    host.wr(12'h228, 8'h43);
    settle;
    drv_chk(1'b1, 1'b1);
  endtask
  // a write while ce is low must be lost; a mid-run reset must clear the control register
  task automatic t_freeze;
    @(posedge clk) ce <= 1'b0;
    host.wr(12'h228, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd_chk("ctl", 12'h228, 8'h43);
    drv_chk(1'b1, 1'b1);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctl", 12'h228, HSD_CONTROL_RESET);
    drv_chk(1'b0, 1'b0);
    check("irq", 8'(overtemp_irq), 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_map;
    t_pwm;
    t_sense;
    t_overtemp;
    t_hv;
    t_freeze;
    finish_test;
  end
endmodule
`default_nettype wire
